// >>> shared/pru_pkg.sv
// Purpose: constants, types and carriers for the processor state relocation unit
// Assumes: decimal quantities travel as binary values of the decimal number, except index words, which travel as bcd digits
// Notes:   timer tick count is overridden at the top for short simulations

`default_nettype none

package pru_pkg;

  // ---------------------------------------------------------------
  // timing
  // ---------------------------------------------------------------
  localparam int CLK_HZ     = 100_000_000;        // processor clock rate
  localparam int TICK_HZ    = 1_000;              // timer rate
  localparam int TICK_CYC   = CLK_HZ / TICK_HZ;   // clocks per timer tick

  // ---------------------------------------------------------------
  // widths and address constants
  // ---------------------------------------------------------------
  localparam int              ADDR_W         = 20;        // six-digit absolute address
  localparam int              REL_W          = 19;        // base-relative address
  localparam int              DIG3_W         = 10;        // three-digit register
  localparam int              TMR_W          = 24;        // timer word width
  localparam logic [19:0]     BASE_UNIT      = 20'h003e8; // base counts in thousands
  localparam logic [ADDR_W-1:0] RSV_BASE_ADDR  = 20'h00046; // reserved base location 70
  localparam logic [ADDR_W-1:0] RSV_LIMIT_ADDR = 20'h00049; // reserved limit location 73
  localparam logic [DIG3_W-1:0] MEM_SIZE_DEF   = 10'h3e7;   // installed size, thousands

  // ---------------------------------------------------------------
  // code points
  // ---------------------------------------------------------------
  localparam logic [3:0] DIGIT_MAX  = 4'h9; // largest decimal digit
  localparam logic [3:0] SIGN_MINUS = 4'hd; // minus sign nibble
  localparam logic [3:0] PLUS_ASC   = 4'hb; // plus written in usascii mode
  localparam logic [3:0] PLUS_EBC   = 4'hc; // plus written in ebcdic mode
  localparam logic [3:0] ZONE_EBC   = 4'hf; // numeric zone, ebcdic
  localparam logic [3:0] ZONE_ASC   = 4'h5; // numeric zone, usascii
  localparam logic [1:0] IDX_FIRST  = 2'h1; // first index slot select
  localparam logic [1:0] IDX_THIRD  = 2'h3; // third index slot select

  // ---------------------------------------------------------------
  // saved status character bit positions
  // ---------------------------------------------------------------
  localparam int ST_MODE = 3; // 8-bit
  localparam int ST_OVF  = 2; // 4-bit
  localparam int ST_CMP  = 0; // 2-bit and 1-bit

  // ---------------------------------------------------------------
  // types
  // ---------------------------------------------------------------
  typedef enum logic [3:0] {
    OP_NONE, OP_BR_REINSTATE, OP_BR_COMM, OP_SCAN_RD, OP_SEARCH, OP_ENTER,
    OP_EXIT, OP_SET_MODE, OP_MOVE_ALPHA, OP_MOVE_NUM, OP_EDIT, OP_OTHER
  } pru_op_e;

  typedef struct packed {
    logic       done;     // execution cycle completes this clock
    pru_op_e    op;       // instruction class
    logic       mode_val; // value for the set mode instruction
    logic       ovf;      // current overflow flag
    logic [1:0] cmp;      // current comparison flags
  } pru_instr_s;

  typedef struct packed {
    logic [DIG3_W-1:0] base;   // contents of location 70
    logic [DIG3_W-1:0] limit;  // contents of location 73
    logic [7:0]        status; // saved status character
  } pru_rsv_s;

  typedef struct packed {
    logic              valid;  // write these to reserved memory
    logic [DIG3_W-1:0] base;   // base before entry
    logic [DIG3_W-1:0] limit;  // limit before entry
    logic [7:0]        status; // packed status character
  } pru_save_s;

  typedef struct packed {
    logic             valid;    // generate an address
    logic             is_instr; // instruction fetch, protection applies
    logic [REL_W-1:0] rel;      // base-relative address
    logic [1:0]       idx_sel;  // index select, zero for none
    logic [31:0]      idx_word; // eight-digit index register
  } pru_agen_s;

endpackage

`default_nettype wire

// >>> core/pru_top.sv
// Purpose: processor control state, timer, relocation and data code helpers
// Assumes: sequencer drives instr and agen on clk; io_done_pin is asynchronous
// Notes:   all outputs registered; one clock latency on every answer except pend_q, set three clocks after io_done_pin rises
`timescale 1ns/100ps
`default_nettype none

module pru_top #(
  parameter int TICK_CYCLES = pru_pkg::TICK_CYC // clocks per timer tick
) (
  input  wire logic                         clk,
  input  wire logic                         srst,
  input  wire logic                         io_done_pin,
  input  wire pru_pkg::pru_instr_s          instr,
  input  wire pru_pkg::pru_rsv_s            rsv,
  input  wire pru_pkg::pru_agen_s           agen,
  input  wire logic                         tmr_clr,
  input  wire logic                         tmr_cmp_wr,
  input  wire logic [pru_pkg::TMR_W-1:0]    tmr_cmp_val,
  input  wire logic [3:0]                   conv_nib,
  input  wire logic                         conv_minus,
  input  wire logic [7:0]                   cmp_a,
  input  wire logic [7:0]                   cmp_b,
  output logic                              pend_q,
  output logic                              normal_q,
  output logic                              mode_q,
  output logic                              irq_branch_q,
  output logic                              seq_next_q,
  output pru_pkg::pru_save_s                save_q,
  output logic [pru_pkg::DIG3_W-1:0]        base_q,
  output logic [pru_pkg::DIG3_W-1:0]        limit_q,
  output logic [pru_pkg::TMR_W-1:0]         tmr_q,
  output logic                              clk_irq_q,
  output logic [pru_pkg::ADDR_W-1:0]        abs_q,
  output logic                              abs_valid_q,
  output logic                              prot_irq_q,
  output logic [1:0]                        idx_slot_q,
  output logic                              unsigned8_q,
  output logic                              conv_digit_q,
  output logic                              conv_is_minus_q,
  output logic [3:0]                        conv_sign_q,
  output logic [7:0]                        conv_byte_q,
  output logic                              alpha_gt_q,
  output logic                              alpha_lt_q
);
  import pru_pkg::*;

  // every check below runs on clk and sleeps through reset
  default clocking cb @(posedge clk); endclocking
  default disable iff (srst);

  // ---------------------------------------------------------------
  // functions
  // ---------------------------------------------------------------
  // six bcd digits to binary
  function automatic logic [19:0] bcd6(input logic [23:0] d);
    logic [19:0] v;
    v = 20'h00000;
    for (int i = 5; i >= 0; i--) begin
      v = 20'(v * 20'd10 + 20'(d[i*4 +: 4]));
    end
    return v;
  endfunction

  // minus only for one code, anything else is plus
  function automatic logic is_minus(input logic [3:0] n);
    return n == SIGN_MINUS;
  endfunction

  // ---------------------------------------------------------------
  // synchroniser and event detect
  // ---------------------------------------------------------------
  logic io_s1_q; // first stage, read only by io_s2_q
  logic io_s2_q; // synchronised level
  logic io_s3_q; // previous level for edge detect
  logic io_evt;  // io completion event

  // two-flop pin synchroniser
  always_ff @(posedge clk) begin
    if (srst) begin
      io_s1_q <= 1'b0;
      io_s2_q <= 1'b0;
      io_s3_q <= 1'b0;
    end else begin
      io_s1_q <= io_done_pin;
      io_s2_q <= io_s1_q;
      io_s3_q <= io_s2_q;
    end
  end
  assign io_evt = io_s2_q & ~io_s3_q;

  // ---------------------------------------------------------------
  // sequencing decisions
  // ---------------------------------------------------------------
  logic take_br;  // automatic interrupt branch now
  logic enter_cs; // entry to control state now
  logic reinst;   // branch reinstate completes now
  logic pend_clr; // pending cleared by handler

  assign take_br  = instr.done & normal_q & pend_q;
  assign enter_cs = take_br | (instr.done & instr.op == OP_BR_COMM);
  assign reinst   = instr.done & ~take_br & instr.op == OP_BR_REINSTATE;
  assign pend_clr = instr.done & ~normal_q & instr.op == OP_SCAN_RD;

  // pending flag, set beats clear
  always_ff @(posedge clk) begin
    if (srst) begin
      pend_q <= 1'b0;
    end else if (io_evt) begin
      pend_q <= 1'b1;
    end else if (pend_clr) begin
      pend_q <= 1'b0;
    end
  end

  // branch or sequence pulses
  always_ff @(posedge clk) begin
    if (srst) begin
      irq_branch_q <= 1'b0;
      seq_next_q   <= 1'b0;
    end else begin
      irq_branch_q <= take_br;
      seq_next_q   <= instr.done & ~take_br;
    end
  end

  // normal/control state flag and code mode
  always_ff @(posedge clk) begin
    if (srst) begin
      normal_q <= 1'b0;
      mode_q   <= 1'b0;
    end else if (enter_cs) begin
      normal_q <= 1'b0;
      mode_q   <= 1'b0;
    end else if (reinst) begin
      normal_q <= 1'b1;
      mode_q   <= rsv.status[ST_MODE];
    end else if (instr.done & instr.op == OP_SET_MODE) begin
      mode_q   <= instr.mode_val;
    end
  end

  // base, limit and saved status
  always_ff @(posedge clk) begin
    if (srst) begin
      base_q  <= '0;
      limit_q <= MEM_SIZE_DEF;
      save_q  <= '0;
    end else begin
      save_q.valid <= enter_cs;
      if (enter_cs) begin
        save_q.base   <= base_q;
        save_q.limit  <= limit_q;
        save_q.status <= {4'h0, mode_q, instr.ovf, instr.cmp};
        base_q        <= '0;
        limit_q       <= MEM_SIZE_DEF;
      end else if (reinst) begin
        base_q  <= rsv.base;
        limit_q <= rsv.limit;
      end
    end
  end

  // ---------------------------------------------------------------
  // timer
  // ---------------------------------------------------------------
  logic [31:0] tick_cnt_q; // clocks since last tick
  logic        tick;       // one timer tick
  logic [TMR_W-1:0] tmr_cmp_q; // second word, loaded by software

  assign tick = tick_cnt_q == 32'(TICK_CYCLES - 1);

  // prescaler to one kilohertz
  always_ff @(posedge clk) begin
    if (srst || tick) begin
      tick_cnt_q <= '0;
    end else begin
      tick_cnt_q <= tick_cnt_q + 32'h1;
    end
  end

  // first and second timer words
  always_ff @(posedge clk) begin
    if (srst) begin
      tmr_q     <= '0;
      tmr_cmp_q <= '0;
    end else begin
      if (tmr_clr) begin
        tmr_q <= '0;
      end else if (tick) begin
        tmr_q <= tmr_q + 24'h000001;
      end
      if (tmr_cmp_wr) begin
        tmr_cmp_q <= tmr_cmp_val;
      end
    end
  end

  // clock interrupt level
  always_ff @(posedge clk) begin
    if (srst) begin
      clk_irq_q <= 1'b0;
    end else begin
      clk_irq_q <= tmr_q >= tmr_cmp_q;
    end
  end

  // ---------------------------------------------------------------
  // address generation and protection
  // ---------------------------------------------------------------
  logic signed [22:0] idx_val; // signed index value
  logic signed [22:0] sum;     // based, indexed address
  logic [11:0]        hi3;     // high digits, wide so indexed sums never wrap
  logic               oob;     // outside base..limit

  always_comb begin
    idx_val = 23'(bcd6(agen.idx_word[23:0]));
    if (is_minus(agen.idx_word[31:28])) begin
      idx_val = -idx_val;
    end
    sum = 23'(base_q * BASE_UNIT) + 23'(agen.rel);
    if (agen.idx_sel != 2'h0) begin
      sum = sum + idx_val;
    end
    hi3 = 12'(23'(sum) / 23'(BASE_UNIT));
    oob = sum < 0 || hi3 < 12'(base_q) || hi3 > 12'(limit_q);
  end

  // registered address result
  always_ff @(posedge clk) begin
    if (srst) begin
      abs_q       <= '0;
      abs_valid_q <= 1'b0;
      prot_irq_q  <= 1'b0;
    end else begin
      abs_q       <= ADDR_W'(sum);
      abs_valid_q <= agen.valid & ~(agen.is_instr & oob);
      prot_irq_q  <= agen.valid & agen.is_instr & oob;
    end
  end

  // index slot an instruction uses, and signedness of bytes
  always_ff @(posedge clk) begin
    if (srst) begin
      idx_slot_q  <= 2'h0;
      unsigned8_q <= 1'b1;
    end else begin
      case (instr.op)
        OP_ENTER, OP_EXIT:     idx_slot_q <= IDX_THIRD;
        OP_SCAN_RD, OP_SEARCH: idx_slot_q <= base_q == '0 ? IDX_FIRST : 2'h0;
        default:               idx_slot_q <= 2'h0;
      endcase
      unsigned8_q <= !(instr.op inside {OP_MOVE_ALPHA, OP_MOVE_NUM, OP_EDIT});
    end
  end

  // ---------------------------------------------------------------
  // data code conversion and compare
  // ---------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (srst) begin
      conv_digit_q    <= 1'b0;
      conv_is_minus_q <= 1'b0;
      conv_sign_q     <= PLUS_EBC;
      conv_byte_q     <= '0;
      alpha_gt_q      <= 1'b0;
      alpha_lt_q      <= 1'b0;
    end else begin
      conv_digit_q    <= conv_nib <= DIGIT_MAX;
      conv_is_minus_q <= is_minus(conv_nib);
      conv_sign_q     <= conv_minus ? SIGN_MINUS :
                         (mode_q ? PLUS_ASC : PLUS_EBC);
      conv_byte_q     <= {mode_q ? ZONE_ASC : ZONE_EBC, conv_nib};
      alpha_gt_q      <= cmp_a > cmp_b;
      alpha_lt_q      <= cmp_a < cmp_b;
    end
  end

  // ---------------------------------------------------------------
  // checks
  // ---------------------------------------------------------------
  chk_pend_set: assert property (io_evt |=> pend_q)
    else $error("pending flag not set by io event");
  chk_irq_branch: assert property (take_br |=> irq_branch_q && !normal_q && base_q == '0)
    else $error("interrupt branch did not enter control state");
  chk_seq_next: assert property (instr.done && !pend_q |=> seq_next_q && !irq_branch_q)
    else $error("sequence step missing");
  chk_pend_clear: assert property (pend_clr && !io_evt |=> !pend_q)
    else $error("scan result descriptor did not clear pending");
  chk_state_set: assert property (!$past(normal_q) && normal_q |-> $past(reinst))
    else $error("normal state entered without reinstate");
  chk_ctrl_inhibit: assert property (!normal_q |=> !irq_branch_q)
    else $error("branch taken in control state");
  chk_timer_tick: assert property (tick && !tmr_clr |=> tmr_q == $past(tmr_q) + 1'b1)
    else $error("timer did not count on tick");
  chk_clk_irq: assert property (tmr_q >= tmr_cmp_q |=> clk_irq_q)
    else $error("clock interrupt missing");
  chk_base_load: assert property (reinst |=>
    base_q == $past(rsv.base) && limit_q == $past(rsv.limit))
    else $error("reinstate load wrong");
  chk_entry_save: assert property (enter_cs |=>
    save_q.valid && save_q.base == $past(base_q) ##1 save_q.valid == $past(enter_cs))
    else $error("entry save wrong");
  chk_prot_irq: assert property (agen.valid && agen.is_instr && oob |=>
    prot_irq_q && !abs_valid_q)
    else $error("protection violation not flagged");

endmodule

`default_nettype wire

// >>> verification/pru_io_model.sv
// Purpose: io subsystem model raising a completion on the async pin
// Assumes: fire is a one-cycle request from the bench
// Notes:   pin rises off the clock edge and holds for a few cycles
`timescale 1ns/100ps
`default_nettype none

module pru_io_model (
  input  wire logic       clk,
  input  wire logic       fire,
  input  wire logic [3:0] lag,
  output logic            io_done_pin
);
  // ---------------------------------------------------------------
  // completion pulse, delayed by lag cycles (prompt or slow)
  // ---------------------------------------------------------------
  initial io_done_pin = 1'b0;
  always @(posedge fire) begin
    repeat (lag) @(posedge clk);
    #3 io_done_pin = 1'b1; // async rise, away from the edge
    repeat (4) @(posedge clk);
    #3 io_done_pin = 1'b0; // level released again
  end
endmodule

`default_nettype wire

// >>> verification/processor_state_relocation_unit_bench.sv
// Purpose: self-checking bench for the state and relocation unit
// Assumes: timer tick shortened to 10 clocks
// Notes:   pulse results are queued by drivers and popped by a monitor
`timescale 1ns/100ps
`default_nettype none

module processor_state_relocation_unit_bench;
  import pru_pkg::*;
  // ---------------------------------------------------------------
  // signals
  // ---------------------------------------------------------------
  logic clk = 0, srst = 1, fire = 0, io_done_pin, tmr_clr = 0, tmr_cmp_wr = 0;
  logic [3:0] lag = 0, conv_nib = 0;
  logic conv_minus = 0, pend_q, normal_q, mode_q, irq_branch_q, seq_next_q, clk_irq_q;
  logic abs_valid_q, prot_irq_q, unsigned8_q, conv_digit_q, conv_is_minus_q;
  logic alpha_gt_q, alpha_lt_q;
  logic [7:0] cmp_a = 0, cmp_b = 0, conv_byte_q;
  logic [3:0] conv_sign_q;
  logic [1:0] idx_slot_q;
  logic [TMR_W-1:0] tmr_cmp_val = 0, tmr_q, v;
  logic [DIG3_W-1:0] base_q, limit_q;
  logic [ADDR_W-1:0] abs_q;
  pru_instr_s instr = '0;
  pru_rsv_s rsv = '0;
  pru_agen_s agen = '0;
  pru_save_s save_q, sv_seen; // sv_seen: save word caught while its pulse stands
  logic [23:0] exp_q[$]; // expected pulse results, oldest first
  logic [31:0] seed = 32'h334c7a09, r;
  int n_errors = 0, tests_run = 0, n;
  localparam logic [23:0] SEQ = 24'h400000, IRQ = 24'h800000;
  localparam logic [23:0] PROT = 24'h200000, AV = 24'h100000;
  pru_op_e ol[5] = '{OP_MOVE_ALPHA, OP_MOVE_NUM, OP_EDIT, OP_OTHER, OP_SEARCH};

  always #5 clk = ~clk; // 100 MHz

  pru_top #(.TICK_CYCLES(10)) dut (
    .clk(clk), .srst(srst), .io_done_pin(io_done_pin), .instr(instr), .rsv(rsv),
    .agen(agen), .tmr_clr(tmr_clr), .tmr_cmp_wr(tmr_cmp_wr), .tmr_cmp_val(tmr_cmp_val),
    .conv_nib(conv_nib), .conv_minus(conv_minus), .cmp_a(cmp_a), .cmp_b(cmp_b),
    .pend_q(pend_q), .normal_q(normal_q), .mode_q(mode_q), .irq_branch_q(irq_branch_q),
    .seq_next_q(seq_next_q), .save_q(save_q), .base_q(base_q), .limit_q(limit_q),
    .tmr_q(tmr_q), .clk_irq_q(clk_irq_q), .abs_q(abs_q), .abs_valid_q(abs_valid_q),
    .prot_irq_q(prot_irq_q), .idx_slot_q(idx_slot_q), .unsigned8_q(unsigned8_q),
    .conv_digit_q(conv_digit_q), .conv_is_minus_q(conv_is_minus_q),
    .conv_sign_q(conv_sign_q), .conv_byte_q(conv_byte_q), .alpha_gt_q(alpha_gt_q),
    .alpha_lt_q(alpha_lt_q));

  pru_io_model io (.clk(clk), .fire(fire), .lag(lag), .io_done_pin(io_done_pin));

  // ---------------------------------------------------------------
  // helpers
  // ---------------------------------------------------------------
  function automatic logic [31:0] xs();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction

  task automatic chk(input logic [31:0] seen, input logic [31:0] expd);
    tests_run++;
    if (seen !== expd) begin
      n_errors++;
      $display("ERROR t=%0t seen=%h expected=%h", $time, seen, expd);
    end
  endtask

  task automatic step(); // drive just after the rising edge
    @(posedge clk);
    #1;
  endtask

  task automatic op(input pru_op_e o, input logic [23:0] e); // completion pulse
    exp_q.push_back(e);
    instr.op = o;
    instr.done = 1'b1;
    step();
    sv_seen = save_q; // save valid stands this cycle only
    instr.done = 1'b0;
    step(); // idle edge, strobe never toggles twice in one step
  endtask

  task automatic gen(input logic ii, input logic [18:0] rel, input logic [1:0] s,
                     input logic [31:0] w, input logic [23:0] e);
    exp_q.push_back(e);
    agen = '{1'b1, ii, rel, s, w};
    step();
    agen.valid = 1'b0;
    step(); // idle edge between requests
  endtask

  task automatic io_event(input logic [3:0] l);
    lag = l;
    fire = 1'b1;
    step();
    fire = 1'b0;
  endtask

  task automatic conv_all(input logic m); // every nibble, given code mode
    for (int k = 0; k < 16; k++) begin
      r = xs();
      conv_nib = k[3:0];
      conv_minus = r[0];
      cmp_a = r[15:8];
      cmp_b = r[23:16];
      step();
      chk(conv_digit_q, k <= 9);
      chk(conv_is_minus_q, k == 13);
      chk(conv_sign_q, conv_minus ? 4'hd : (m ? 4'hb : 4'hc));
      chk(conv_byte_q, {(m ? 4'h5 : 4'hf), k[3:0]});
      chk({alpha_gt_q, alpha_lt_q}, {cmp_a > cmp_b, cmp_a < cmp_b});
    end
  endtask

  task automatic wait_change(output int c); // cycles until tmr_q moves
    v = tmr_q;
    c = 0;
    while (tmr_q === v && c < 40) begin
      step();
      c++;
    end
  endtask

  task automatic wrap_up();
    $display("comparisons %0d, mismatches %0d", tests_run, n_errors);
    if (n_errors == 0 && tests_run > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask

  // ---------------------------------------------------------------
  // monitor: pops the oldest note whenever a pulse result appears
  // ---------------------------------------------------------------
  always @(negedge clk) begin
    if (srst === 1'b0 && (irq_branch_q | seq_next_q | prot_irq_q | abs_valid_q) === 1'b1) begin
      if (exp_q.size() == 0) chk({8'h0, irq_branch_q, seq_next_q, prot_irq_q, abs_valid_q,
        abs_q}, 32'hffffffff);
      else chk({irq_branch_q, seq_next_q, prot_irq_q, abs_valid_q,
        (abs_valid_q ? abs_q : 20'h0)}, exp_q.pop_front());
    end
  end

  // watchdog against a hang
  initial begin
    repeat (4000) @(posedge clk);
    n_errors++;
    $display("watchdog expired");
    wrap_up();
  end

  // ---------------------------------------------------------------
  // main sequence
  // ---------------------------------------------------------------
  initial begin
    repeat (10) @(posedge clk);
    #1 srst = 1'b0;
    chk(limit_q, 10'd999);
    chk({normal_q, pend_q}, 2'b00);
    io_event(4'd1);
    repeat (8) step();
    chk(pend_q, 1);
    op(OP_OTHER, SEQ);
    op(OP_SCAN_RD, SEQ);
    chk({pend_q, idx_slot_q}, 3'b001);
    op(OP_ENTER, SEQ);
    chk(idx_slot_q, 2'h3);
    op(OP_EXIT, SEQ);
    chk(idx_slot_q, 2'h3);
    $display("test control state done");
    rsv = '{10'd137, 10'd200, 8'h08};
    op(OP_BR_REINSTATE, SEQ);
    chk({normal_q, mode_q, base_q, limit_q}, {2'b11, 10'd137, 10'd200});
    op(OP_OTHER, SEQ);
    for (int k = 0; k < 8; k++) begin
      r = xs();
      gen(r[20], 19'(r % 60000), 2'h0, xs(), AV | 24'(137000 + r % 60000));
    end
    gen(1, 19'd63999, 2'h0, 0, AV | 24'd200999);
    gen(1, 19'd64000, 2'h0, 0, PROT);
    gen(0, 19'd70000, 2'h0, 0, AV | 24'd207000);
    gen(0, 19'd1000, 2'h1, 32'h09000123, AV | 24'd138123);
    gen(0, 19'd1000, 2'h3, 32'hd0000456, AV | 24'd137544);
    gen(1, 19'd0, 2'h2, 32'hd0000001, PROT);
    $display("test relocation done");
    conv_all(1);
    instr.mode_val = 1'b0;
    op(OP_SET_MODE, SEQ);
    chk(mode_q, 0);
    conv_all(0);
    foreach (ol[i]) begin
      op(ol[i], SEQ);
      chk(unsigned8_q, i > 2);
    end
    instr.mode_val = 1'b1;
    op(OP_SET_MODE, SEQ);
    $display("test data codes done");
    instr.ovf = 1'b1;
    instr.cmp = 2'b10;
    io_event(4'd6);
    repeat (12) step();
    chk(pend_q, 1);
    op(OP_OTHER, IRQ);
    chk({normal_q, mode_q, base_q, limit_q}, {2'b00, 10'd0, 10'd999});
    chk(sv_seen, {1'b1, 10'd137, 10'd200, 8'h0e});
    op(OP_OTHER, SEQ);
    op(OP_SCAN_RD, SEQ);
    rsv = '{10'd5, 10'd9, 8'h00};
    instr.ovf = 1'b0;
    instr.cmp = 2'b01;
    op(OP_BR_REINSTATE, SEQ);
    op(OP_BR_COMM, SEQ);
    chk({normal_q, base_q, limit_q}, {1'b0, 10'd0, 10'd999});
    chk(sv_seen, {1'b1, 10'd5, 10'd9, 8'h01});
    gen(1, 19'd299999, 2'h1, 32'h00999999, PROT);
    $display("test interrupt branch done");
    tmr_cmp_val = 24'hffffff;
    {tmr_cmp_wr, tmr_clr} = 2'b11;
    step();
    {tmr_cmp_wr, tmr_clr} = 2'b00;
    repeat (2) step();
    chk(clk_irq_q, 0);
    wait_change(n);
    wait_change(n);
    chk(n, 10);
    tmr_cmp_val = tmr_q + 24'd2;
    tmr_cmp_wr = 1'b1;
    step();
    tmr_cmp_wr = 1'b0;
    repeat (30) step();
    chk(clk_irq_q, 1);
    v = tmr_q;
    repeat (20) step();
    chk(tmr_q, v + 24'd2);
    tmr_clr = 1'b1;
    step();
    tmr_clr = 1'b0;
    chk(tmr_q, 0);
    repeat (2) step();
    chk(clk_irq_q, 0);
    $display("test timer done");
    chk(exp_q.size(), 0);
    wrap_up();
  end
endmodule

`default_nettype wire
